// >>> ppi_pkg.sv
// Package for the port integration block: register offsets, widths,
// reset values and pin positions shared by the design and its tests.
// Assumes an 8-bit register port with a 9-bit byte address.
package ppi_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [8:0] OFS_PORT_A_DATA     = 9'h000;
    localparam logic [8:0] OFS_PORT_A_DIR      = 9'h002;
    localparam logic [8:0] OFS_PORT_C_DATA     = 9'h004;
    localparam logic [8:0] OFS_PORT_D_DATA     = 9'h005;
    localparam logic [8:0] OFS_PORT_C_DIR      = 9'h006;
    localparam logic [8:0] OFS_PORT_D_DIR      = 9'h007;
    localparam logic [8:0] OFS_RSVD_LOW_FIRST  = 9'h008;
    localparam logic [8:0] OFS_RSVD_LOW_LAST   = 9'h019;
    localparam logic [8:0] OFS_PORT_A_IN       = 9'h120;
    localparam logic [8:0] OFS_RSVD_SINGLE     = 9'h121;
    localparam logic [8:0] OFS_PORT_A_DRIVE    = 9'h122;
    localparam logic [8:0] OFS_RSVD_HIGH_FIRST = 9'h123;
    localparam logic [8:0] OFS_RSVD_HIGH_LAST  = 9'h17f;

    // Port widths
    localparam int unsigned PA_W = 6;
    localparam int unsigned PC_W = 2;
    localparam int unsigned PD_W = 8;
    localparam int unsigned SPI_W = 4;
    localparam int unsigned PIN_W = 16;

    // Pin positions inside the sampled pin vector {pd, pc, pa}
    localparam int unsigned PIN_PA_LSB = 0;
    localparam int unsigned PIN_PC_LSB = 6;
    localparam int unsigned PIN_PD_LSB = 8;

    // Port C pin roles while the die link owns them
    localparam int unsigned PC_CLK_BIT = 0;
    localparam int unsigned PC_INT_BIT = 1;

    // Reset values
    localparam logic [5:0] RST_PORT_A = 6'h00;
    localparam logic [1:0] RST_PORT_C = 2'h0;
    localparam logic [7:0] RST_PORT_D = 8'h00;
    localparam logic [7:0] RST_RDATA  = 8'h00;

endpackage : ppi_pkg

// >>> ppi_port_integration.sv
// Port integration logic for ports A, C and D: data, direction, input
// readback and reduced drive registers plus the peripheral pin muxing.
// Assumes a single-clock register port, pads that resolve out/oe, and
// SPI and die link blocks that present their own out/oe per pin.
//
// Contract
// - GPIO direction bit 1 drives the pin, 0 makes it a high-impedance input.
// - A peripheral owning a pin sets its direction; stored direction bit unchanged.
// - Data read gives synced pin where direction 0, stored data where 1.
// - Data writes always store, reach the pin only as GPIO output.
// - Port A input register read-only, returns synced pins 5..0, reset-free.
// - Port A drive bit 1 selects one-sixth drive, 0 full drive.
// - Reduced drive bit has no effect while its pin is an input.
// - Reserved locations read zero; writes to them do nothing.
// - All pins GPIO; all but port A pins 5 and 4 also peripheral.
// - Port A pins 5..0 GPIO, pins 3..0 switchable to the SPI.
// - Port C pin 1 link interrupt in, pin 0 link clock out.
// - Pull-down on port C pin 1 while used as link interrupt input.
// - Link interrupt synchronised; asynchronous bypass in stop mode for wake-up.
// - Port D carries link data: eight bits wide, low four in narrow mode.
// - Port D internal only; pull-downs on lines used as link inputs.
// - Port D direction register, eight bits, read/write anytime, reset zero.
//
// Our own choice: the strobed register port.

`timescale 1ns/1ps

module ppi_port_integration (
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [8:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Port A pads
    input  wire logic [5:0] pa_in,
    output logic      [5:0] pa_out,
    output logic      [5:0] pa_oe,
    output logic      [5:0] pa_reduced_drive,
    // SPI side of port A pins 3..0
    input  wire logic       spi_en,
    input  wire logic [3:0] spi_out,
    input  wire logic [3:0] spi_oe,
    output logic      [3:0] spi_in,
    // Port C pads
    input  wire logic [1:0] pc_in,
    output logic      [1:0] pc_out,
    output logic      [1:0] pc_oe,
    output logic            pc_pin1_pulldown,
    // Port D internal lines
    input  wire logic [7:0] pd_in,
    output logic      [7:0] pd_out,
    output logic      [7:0] pd_oe,
    output logic      [7:0] pd_pulldown,
    // Die link side
    input  wire logic       d2d_en,
    input  wire logic       d2d_wide,
    input  wire logic       stop_mode,
    input  wire logic       die_link_clock_out,
    input  wire logic [7:0] d2d_dat_out,
    input  wire logic [7:0] d2d_dat_oe,
    output logic      [7:0] d2d_dat_in,
    output logic            die_link_interrupt_in,
    output logic            die_link_interrupt_wake
);

    // Readback mix: stored data where output, synced pin where input
    function automatic logic [7:0] port_read(input logic [7:0] data,
                                             input logic [7:0] dir,
                                             input logic [7:0] pins);
        port_read = (data & dir) | (pins & ~dir);
    endfunction

    // Address decode for the reserved windows
    function automatic logic is_reserved(input logic [8:0] a);
        is_reserved = (a == 9'h001) || (a == 9'h003)
                   || (a >= ppi_pkg::OFS_RSVD_LOW_FIRST && a <= ppi_pkg::OFS_RSVD_LOW_LAST)
                   || (a == ppi_pkg::OFS_RSVD_SINGLE)
                   || (a >= ppi_pkg::OFS_RSVD_HIGH_FIRST && a <= ppi_pkg::OFS_RSVD_HIGH_LAST);
    endfunction

    logic [5:0]  port_a_data_q;
    logic [5:0]  port_a_dir_q;
    logic [5:0]  port_a_drive_strength_q;
    logic [1:0]  port_c_data_q;
    logic [1:0]  port_c_direction_q;
    logic [7:0]  port_d_data_q;
    logic [7:0]  port_d_direction_q;
    logic [15:0] sync1_q;
    logic [15:0] sync2_q;
    logic [15:0] sync3_q;
    logic [15:0] pins_q;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic [7:0]  pd_owned;
    logic [5:0]  pa_sync;
    logic [1:0]  pc_sync;
    logic [7:0]  pd_sync;

    // Three-stage pin sampler; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        sync1_q <= {pd_in, pc_in, pa_in};
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    // Accept a pin change once stages two and three agree, filtering
    // single-cycle glitches; no reset so input readback is reset-free
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 16; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
                pins_q[i] <= sync3_q[i];
            end
        end
    end

    assign pa_sync = pins_q[ppi_pkg::PIN_PA_LSB +: 6];
    assign pc_sync = pins_q[ppi_pkg::PIN_PC_LSB +: 2];
    assign pd_sync = pins_q[ppi_pkg::PIN_PD_LSB +: 8];

    // Port A registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port_a_data_q           <= ppi_pkg::RST_PORT_A;
            port_a_dir_q            <= ppi_pkg::RST_PORT_A;
            port_a_drive_strength_q <= ppi_pkg::RST_PORT_A;
        end else if (reg_wr) begin
            if (reg_addr == ppi_pkg::OFS_PORT_A_DATA) begin
                port_a_data_q <= reg_wdata[5:0];
            end
            // Direction is stored even while the SPI owns the pins
            if (reg_addr == ppi_pkg::OFS_PORT_A_DIR) begin
                port_a_dir_q <= reg_wdata[5:0];
            end
            if (reg_addr == ppi_pkg::OFS_PORT_A_DRIVE) begin
                port_a_drive_strength_q <= reg_wdata[5:0];
            end
        end
    end

    // Port C and D registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port_c_data_q      <= ppi_pkg::RST_PORT_C;
            port_c_direction_q <= ppi_pkg::RST_PORT_C;
            port_d_data_q      <= ppi_pkg::RST_PORT_D;
            port_d_direction_q <= ppi_pkg::RST_PORT_D;
        end else if (reg_wr) begin
            if (reg_addr == ppi_pkg::OFS_PORT_C_DATA) begin
                port_c_data_q <= reg_wdata[1:0];
            end
            if (reg_addr == ppi_pkg::OFS_PORT_C_DIR) begin
                port_c_direction_q <= reg_wdata[1:0];
            end
            if (reg_addr == ppi_pkg::OFS_PORT_D_DATA) begin
                port_d_data_q <= reg_wdata;
            end
            if (reg_addr == ppi_pkg::OFS_PORT_D_DIR) begin
                port_d_direction_q <= reg_wdata;
            end
        end
    end

    // Read decode; reserved and unmapped addresses answer zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            ppi_pkg::OFS_PORT_A_DATA: begin
                rdata_d = port_read({2'b00, port_a_data_q}, {2'b00, port_a_dir_q},
                                    {2'b00, pa_sync});
            end
            ppi_pkg::OFS_PORT_A_DIR:   rdata_d = {2'b00, port_a_dir_q};
            ppi_pkg::OFS_PORT_C_DATA: begin
                rdata_d = port_read({6'h00, port_c_data_q}, {6'h00, port_c_direction_q},
                                    {6'h00, pc_sync});
            end
            ppi_pkg::OFS_PORT_D_DATA: begin
                rdata_d = port_read(port_d_data_q, port_d_direction_q, pd_sync);
            end
            ppi_pkg::OFS_PORT_C_DIR:   rdata_d = {6'h00, port_c_direction_q};
            ppi_pkg::OFS_PORT_D_DIR:   rdata_d = port_d_direction_q;
            ppi_pkg::OFS_PORT_A_IN:    rdata_d = {2'b00, pa_sync};
            ppi_pkg::OFS_PORT_A_DRIVE: rdata_d = {2'b00, port_a_drive_strength_q};
            default:                   rdata_d = 8'h00;
        endcase
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= ppi_pkg::RST_RDATA;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    // Port A: pins 5..4 are GPIO only, 3..0 go to the SPI when enabled
    always_comb begin
        pa_out = port_a_data_q;
        pa_oe  = port_a_dir_q;
        if (spi_en) begin
            pa_out[3:0] = spi_out;
            pa_oe[3:0]  = spi_oe;
        end
    end

    // Reduced drive only matters on driven pins
    assign pa_reduced_drive = port_a_drive_strength_q & pa_oe;
    assign spi_in           = pa_sync[3:0];

    // Port C: link clock out on pin 0, link interrupt in on pin 1
    always_comb begin
        pc_out = port_c_data_q;
        pc_oe  = port_c_direction_q;
        if (d2d_en) begin
            pc_out[ppi_pkg::PC_CLK_BIT] = die_link_clock_out;
            pc_oe[ppi_pkg::PC_CLK_BIT]  = 1'b1;
            pc_out[ppi_pkg::PC_INT_BIT] = 1'b0;
            pc_oe[ppi_pkg::PC_INT_BIT]  = 1'b0;
        end
    end

    assign pc_pin1_pulldown      = d2d_en;
    assign die_link_interrupt_in = d2d_en & pc_sync[ppi_pkg::PC_INT_BIT];
    // Unsampled path: the clock is stopped, so only a raw level can wake
    assign die_link_interrupt_wake = d2d_en & stop_mode & pc_in[ppi_pkg::PC_INT_BIT];

    // Port D lines owned by the link: all eight wide, low four narrow
    assign pd_owned = d2d_en ? (d2d_wide ? 8'hff : 8'h0f) : 8'h00;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pd_out[i] = pd_owned[i] ? d2d_dat_out[i] : port_d_data_q[i];
            pd_oe[i]  = pd_owned[i] ? d2d_dat_oe[i] : port_d_direction_q[i];
        end
    end

    // Pull-downs on link lines currently acting as inputs
    assign pd_pulldown = pd_owned & ~d2d_dat_oe;
    assign d2d_dat_in  = pd_sync & pd_owned;

    // Checks on the register port and pin muxing
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_dir_d_readback: assert property (
        reg_wr && reg_addr == ppi_pkg::OFS_PORT_D_DIR ##1
        reg_rd && reg_addr == ppi_pkg::OFS_PORT_D_DIR
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("port d direction readback differs from write");

    a_data_a_mix: assert property (
        reg_rd && reg_addr == ppi_pkg::OFS_PORT_A_DATA
        |=> reg_rdata == {2'b00, ($past(port_a_data_q) & $past(port_a_dir_q))
                               | ($past(pa_sync) & ~$past(port_a_dir_q))})
        else $error("port a data read mix wrong");

    a_input_a_read: assert property (
        reg_rd && reg_addr == ppi_pkg::OFS_PORT_A_IN
        |=> reg_rdata == {2'b00, $past(pa_sync)})
        else $error("port a input read wrong");

    a_reserved_zero: assert property (
        reg_rd && is_reserved(reg_addr) |=> reg_rdata == 8'h00)
        else $error("reserved read not zero");

    a_rdata_one_cycle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    a_spi_owns_pins: assert property (
        spi_en |-> pa_oe[3:0] == spi_oe && pa_oe[5:4] == port_a_dir_q[5:4]
                   && pa_out[3:0] == spi_out)
        else $error("spi pin ownership wrong");

    a_gpio_direction: assert property (
        !spi_en |-> pa_oe == port_a_dir_q && pa_out == port_a_data_q)
        else $error("gpio direction not applied");

    a_dir_kept_owned: assert property (
        spi_en && !(reg_wr && reg_addr == ppi_pkg::OFS_PORT_A_DIR)
        |=> $stable(port_a_dir_q))
        else $error("direction changed by ownership");

    a_drive_on_input: assert property (
        (pa_reduced_drive & ~pa_oe) == 6'h00
        && pa_reduced_drive == (port_a_drive_strength_q & pa_oe))
        else $error("reduced drive active on input");

    a_link_pin_c: assert property (
        d2d_en |-> pc_pin1_pulldown && !pc_oe[1] && pc_oe[0]
                   && pc_out[0] == die_link_clock_out)
        else $error("port c link roles wrong");

    a_narrow_mode_gpio: assert property (
        d2d_en && !d2d_wide |-> pd_oe[7:4] == port_d_direction_q[7:4]
                                && pd_pulldown[7:4] == 4'h0)
        else $error("narrow mode upper lines not gpio");

    a_sync_settle: assert property (
        $stable(pa_in) [*5] |=> pa_sync == $past(pa_in))
        else $error("synchronised pins lag too long");

    a_write_ignored: assert property (
        reg_wr && (reg_addr == ppi_pkg::OFS_PORT_A_IN || is_reserved(reg_addr))
        |=> $stable(port_a_data_q) && $stable(port_a_dir_q) && $stable(port_a_drive_strength_q)
            && $stable(port_c_data_q) && $stable(port_c_direction_q)
            && $stable(port_d_data_q) && $stable(port_d_direction_q))
        else $error("write to read-only or reserved location took effect");

    a_dir_c_readback: assert property (
        reg_rd && reg_addr == ppi_pkg::OFS_PORT_C_DIR
        |=> reg_rdata == {6'h00, $past(port_c_direction_q)})
        else $error("port c direction readback wrong");

    a_c_gpio_mode: assert property (
        !d2d_en |-> pc_oe == port_c_direction_q && pc_out == port_c_data_q
                    && !pc_pin1_pulldown)
        else $error("port c not gpio while link disabled");

    a_link_int_gated: assert property (
        !d2d_en |-> !die_link_interrupt_in && d2d_dat_in == 8'h00)
        else $error("link inputs active while link disabled");

    a_wake_bypass: assert property (
        !(d2d_en && stop_mode) |-> !die_link_interrupt_wake)
        else $error("wake bypass active outside stop");

    a_pd_owned_drive: assert property (
        ((pd_out & pd_owned) == (d2d_dat_out & pd_owned))
        && ((pd_oe & ~pd_owned) == (port_d_direction_q & ~pd_owned)))
        else $error("port d line owner wrong");

    a_wide_all_owned: assert property (
        d2d_en && d2d_wide |-> pd_oe == d2d_dat_oe && pd_pulldown == ~d2d_dat_oe)
        else $error("wide mode lines not all owned");

    c_spi_read: cover property (spi_en && reg_rd && reg_addr == ppi_pkg::OFS_PORT_A_DATA);
    c_narrow_link: cover property (d2d_en && !d2d_wide && |pd_pulldown[3:0]);
    c_stop_wake: cover property (die_link_interrupt_wake);
    c_dir_write_read: cover property (
        reg_wr && reg_addr == ppi_pkg::OFS_PORT_C_DIR ##1 reg_rd);
    c_wide_read: cover property (d2d_en && d2d_wide && reg_rd);

endmodule : ppi_port_integration

// >>> ppi_pin_model.sv
// Far-side pad model for ports A, C and D of the port integration block.
// Assumes the outside source always drives a line the block releases.
`timescale 1ns/1ps

module ppi_pin_model (
    input  wire logic [5:0] pa_out,
    input  wire logic [5:0] pa_oe,
    input  wire logic [1:0] pc_out,
    input  wire logic [1:0] pc_oe,
    input  wire logic [7:0] pd_out,
    input  wire logic [7:0] pd_oe,
    input  wire logic [5:0] ext_pa,
    input  wire logic [1:0] ext_pc,
    input  wire logic [7:0] ext_pd,
    output logic      [5:0] pa_in,
    output logic      [1:0] pc_in,
    output logic      [7:0] pd_in
);
    // Driven lines show the block, released lines the outside source
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_pa);
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext_pc);
    // Port D source is the companion die, so pull-downs never win here
    assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_pd);
endmodule // ppi_pin_model

// >>> ppi_port_integration_tb.sv
// Self-checking bench for the port integration block: registers, pin
// muxing with SPI and die link. Assumes ppi_pkg and the pad model.
`timescale 1ns/1ps

module ppi_port_integration_tb;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [5:0] pa_in, pa_out, pa_oe, pa_rdrv;
    logic [5:0] ext_pa = 6'h00;
    logic       spi_en = 1'b0;
    logic [3:0] spi_out = 4'h0, spi_oe = 4'h0, spi_in;
    logic [1:0] pc_in, pc_out, pc_oe;
    logic [1:0] ext_pc = 2'h0;
    logic       pc_pd, lint, lwake;
    logic [7:0] pd_in, pd_out, pd_oe, pd_pd, d2d_dat_in;
    logic [7:0] ext_pd = 8'h00, d2d_dat_out = 8'h00, d2d_dat_oe = 8'h00;
    logic       d2d_en = 1'b0, d2d_wide = 1'b0, stop_mode = 1'b0, lclk = 1'b0;
    int         bad_count = 0;
    int         compares = 0;
    int         seed = 76109;
    logic [7:0] dat, dir, drv, own, dird, pin, oex;
    logic [8:0] rsvd [9] = '{9'h001, 9'h003, 9'h008, 9'h00d, 9'h019,
                             9'h121, 9'h123, 9'h150, 9'h17f};

    // 125 MHz bus clock
    always #4 core_clk = ~core_clk;

    ppi_port_integration i_dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_reduced_drive(pa_rdrv),
        .spi_en(spi_en), .spi_out(spi_out), .spi_oe(spi_oe), .spi_in(spi_in),
        .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe), .pc_pin1_pulldown(pc_pd),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pulldown(pd_pd),
        .d2d_en(d2d_en), .d2d_wide(d2d_wide), .stop_mode(stop_mode),
        .die_link_clock_out(lclk), .d2d_dat_out(d2d_dat_out),
        .d2d_dat_oe(d2d_dat_oe), .d2d_dat_in(d2d_dat_in),
        .die_link_interrupt_in(lint), .die_link_interrupt_wake(lwake));

    ppi_pin_model i_pins (
        .pa_out(pa_out), .pa_oe(pa_oe), .pc_out(pc_out), .pc_oe(pc_oe),
        .pd_out(pd_out), .pd_oe(pd_oe), .ext_pa(ext_pa), .ext_pc(ext_pc),
        .ext_pd(ext_pd), .pa_in(pa_in), .pc_in(pc_in), .pd_in(pd_in));

    // Expected line level: driven value where enabled, else outside value
    function automatic logic [7:0] lvl(input logic [7:0] oe, input logic [7:0] o,
                                       input logic [7:0] e);
        return (oe & o) | (~oe & e);
    endfunction

    task automatic chk_val(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Strobe stays up until the next task or sync lowers it, so
    // back-to-back accesses never assign a strobe twice in one step
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask

    // Read data stands only in the cycle after the strobe; taken at
    // the edge that ends that cycle, before it is overwritten
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        chk_val($sformatf("rdata at %h", a), exp, reg_rdata);
    endtask

    // Sampler needs four edges; six leaves margin for the read
    task automatic sync;
        reg_wr <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog well beyond the couple of hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        finish_test;
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd(ppi_pkg::OFS_PORT_D_DIR, 8'h00);
        rd(ppi_pkg::OFS_PORT_A_DRIVE, 8'h00);
        foreach (rsvd[i]) begin
            wr(rsvd[i], 8'hff);
            rd(rsvd[i], 8'h00);
        end
        $display("test reserved done");
        for (int i = 0; i < 4; i++) begin
            dird = (i == 0) ? 8'hff : 8'($random(seed));
            wr(ppi_pkg::OFS_PORT_D_DIR, dird);
            rd(ppi_pkg::OFS_PORT_D_DIR, dird);
        end
        $display("test port d direction done");
        // Port A as GPIO, corners all-in and all-out first
        for (int i = 0; i < 6; i++) begin
            dat = 8'($random(seed));
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            drv = 8'($random(seed));
            ext_pa <= 6'($random(seed));
            wr(ppi_pkg::OFS_PORT_A_DATA, dat);
            wr(ppi_pkg::OFS_PORT_A_DIR, dir);
            sync;
            pin = lvl(dir, dat, {2'b00, ext_pa}) & 8'h3f;
            chk_val("pa_oe", dir & 8'h3f, {2'b00, pa_oe});
            chk_val("pa_out", dat & dir & 8'h3f, {2'b00, pa_out & pa_oe});
            rd(ppi_pkg::OFS_PORT_A_DATA, pin);
            wr(ppi_pkg::OFS_PORT_A_IN, ~pin);
            rd(ppi_pkg::OFS_PORT_A_IN, pin);
            wr(ppi_pkg::OFS_PORT_A_DRIVE, drv);
            rd(ppi_pkg::OFS_PORT_A_DRIVE, drv & 8'h3f);
            chk_val("pa_reduced_drive", drv & dir & 8'h3f, {2'b00, pa_rdrv});
        end
        $display("test port a gpio done");
        @(posedge core_clk);
        spi_en <= 1'b1;
        spi_oe <= 4'($random(seed));
        spi_out <= 4'($random(seed));
        ext_pa <= 6'($random(seed));
        sync;
        chk_val("pa_oe spi", {2'b00, dir[5:4], spi_oe}, {2'b00, pa_oe});
        chk_val("pa_out spi", {4'h0, spi_out & spi_oe}, {4'h0, pa_out[3:0] & pa_oe[3:0]});
        chk_val("spi_in", lvl({4'h0, spi_oe}, {4'h0, spi_out}, {4'h0, ext_pa[3:0]}),
                {4'h0, spi_in});
        pin = lvl({2'b00, dir[5:4], spi_oe}, {2'b00, dat[5:4], spi_out}, {2'b00, ext_pa});
        rd(ppi_pkg::OFS_PORT_A_DATA, ((dat & dir) | (pin & ~dir)) & 8'h3f);
        rd(ppi_pkg::OFS_PORT_A_DIR, dir & 8'h3f);
        spi_en <= 1'b0;
        $display("test spi done");
        wr(ppi_pkg::OFS_PORT_C_DATA, 8'h02);
        wr(ppi_pkg::OFS_PORT_C_DIR, 8'h03);
        sync;
        chk_val("pc_oe gpio", 8'h03, {6'h00, pc_oe});
        rd(ppi_pkg::OFS_PORT_C_DATA, 8'h02);
        d2d_en <= 1'b1;
        lclk <= 1'b1;
        ext_pc <= 2'b10;
        sync;
        chk_val("pc_oe link", 8'h01, {6'h00, pc_oe});
        chk_val("pc_out clock", 8'h01, {7'h00, pc_out[0]});
        chk_val("pc pulldown", 8'h01, {7'h00, pc_pd});
        chk_val("link int", 8'h01, {7'h00, lint});
        rd(ppi_pkg::OFS_PORT_C_DIR, 8'h03);
        // Bypass must show a fresh level before the sampler can
        @(posedge core_clk);
        stop_mode <= 1'b1;
        ext_pc <= 2'b00;
        sync;
        ext_pc <= 2'b10;
        #1;
        chk_val("wake", 8'h01, {7'h00, lwake});
        chk_val("link int held", 8'h00, {7'h00, lint});
        $display("test port c link done");
        dat = 8'($random(seed));
        wr(ppi_pkg::OFS_PORT_D_DATA, dat);
        sync;
        for (int w = 0; w < 2; w++) begin
            @(posedge core_clk);
            d2d_wide <= w[0];
            d2d_dat_oe <= 8'($random(seed));
            d2d_dat_out <= 8'($random(seed));
            ext_pd <= 8'($random(seed));
            own = w[0] ? 8'hff : 8'h0f;
            sync;
            oex = (own & d2d_dat_oe) | (~own & dird);
            pin = (own & d2d_dat_out) | (~own & dat);
            chk_val("pd_oe", oex, pd_oe);
            chk_val("pd_out", pin, pd_out);
            chk_val("pd_pulldown", own & ~d2d_dat_oe, pd_pd);
            chk_val("d2d_dat_in", own & lvl(d2d_dat_oe, d2d_dat_out, ext_pd),
                    d2d_dat_in);
            rd(ppi_pkg::OFS_PORT_D_DATA, (dat & dird) | (~dird & lvl(oex, pin, ext_pd)));
        end
        rd(ppi_pkg::OFS_PORT_D_DIR, dird);
        $display("test port d link done");
        finish_test;
    end
endmodule // ppi_port_integration_tb
